// File: rtl/swdt_system_watchdog.v
/*
  System watchdog countdown timer with seconds or minutes resolution.
  Assumes commands are one-cycle pulses from logic on mclk_in, so no
  synchroniser is used, and that software initialises before anything else.
*/
`timescale 1ns/10ps
`include "swdt_defs.vh"

module swdt_system_watchdog #(
  parameter SEC_CYCLES = `SWDT_SEC_CYCLES,
  parameter RST_PULSE  = `SWDT_RST_PULSE_CYC
) (
  input  wire        mclk_in,
  input  wire        rst_in,
  input  wire        timer_init_cmd_in,
  input  wire        timeout_config_cmd_in,
  input  wire [31:0] timeout_seconds_in,
  input  wire        countdown_start_cmd_in,
  input  wire        countdown_kick_cmd_in,
  input  wire        countdown_stop_cmd_in,
  output wire        initialized_out,
  output wire        running_out,
  output wire        minute_mode_out,
  output wire [25:0] count_out,
  output wire        system_reset_out
);

  // Countdown state codes.
  localparam [1:0]  ST_IDLE   = 2'h0;
  localparam [1:0]  ST_RUN    = 2'h1;

  // Last prescaler value before a one-second tick.
  localparam [31:0] SEC_LAST  = SEC_CYCLES - 1;

  // Last seconds index before a one-minute tick.
  localparam [5:0]  MIN_LAST  = `SWDT_SECS_PER_MIN - 1;

  // Length of the system reset pulse in clock cycles.
  localparam [7:0]  PULSE_LEN = RST_PULSE;

  // Largest minute count that the 26-bit counter can hold.
  localparam [31:0] COUNT_MAX = 32'h03FFFFFF;

  // Configuration held between config commands.
  reg        initialized;
  reg        next_initialized;
  reg        cfg_minutes;
  reg        next_cfg_minutes;
  reg [25:0] cfg_count;
  reg [25:0] next_cfg_count;

  // Countdown state, remaining count and tick dividers.
  reg [1:0]  state;
  reg [1:0]  next_state;
  reg [25:0] count;
  reg [25:0] next_count;
  reg [31:0] presc;
  reg [31:0] next_presc;
  reg [5:0]  min_div;
  reg [5:0]  next_min_div;

  // Expiry strobe and reset pulse timer.
  reg        expire;
  reg [7:0]  rst_cnt;
  reg [7:0]  next_rst_cnt;
  reg        sys_rst;
  reg        next_sys_rst;

  wire        fine_req;
  wire [31:0] coarse;
  wire [25:0] coarse_cnt;
  wire        sec_tick;
  wire        min_last;
  wire        cnt_tick;
  wire        reload;
  wire        stop_now;
  wire        running;

  assign fine_req   = (timeout_seconds_in <= `SWDT_FINE_MAX);
  assign coarse     = timeout_seconds_in / `SWDT_SECS_PER_MIN + 32'h00000001;

  // Very long timeouts clip at the largest count rather than wrap.
  assign coarse_cnt = (coarse > COUNT_MAX) ? COUNT_MAX[25:0] : coarse[25:0];
  assign sec_tick   = (presc == SEC_LAST);
  assign min_last   = (min_div == MIN_LAST);
  assign cnt_tick   = sec_tick && (!cfg_minutes || min_last);
  assign reload     = countdown_start_cmd_in || countdown_kick_cmd_in;
  assign stop_now   = countdown_stop_cmd_in || !initialized;
  assign running    = (state == ST_RUN);

  // Init is sticky; a config before init is ignored.
  always @* begin
    next_initialized = initialized;
    next_cfg_minutes = cfg_minutes;
    next_cfg_count   = cfg_count;
    if (timer_init_cmd_in) begin
      next_initialized = 1'b1;
    end
    if (timeout_config_cmd_in && initialized) begin
      next_cfg_minutes = !fine_req;
      if (fine_req) begin
        next_cfg_count = timeout_seconds_in[25:0];
      end else begin
        next_cfg_count = coarse_cnt;
      end
    end
  end

  // Stop has priority over start or kick issued in the same cycle.
  always @* begin
    next_state   = state;
    next_count   = count;
    next_presc   = presc;
    next_min_div = min_div;
    expire       = 1'b0;
    if (stop_now) begin
      next_state   = ST_IDLE;
      next_presc   = 32'h00000000;
      next_min_div = 6'h00;
    end else if (reload) begin
      next_state   = ST_RUN;
      next_count   = cfg_count;
      next_presc   = 32'h00000000;
      next_min_div = 6'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_RUN: begin
          if (sec_tick) begin
            next_presc = 32'h00000000;
          end else begin
            next_presc = presc + 32'h00000001;
          end
          if (sec_tick) begin
            if (min_last) begin
              next_min_div = 6'h00;
            end else begin
              next_min_div = min_div + 6'h01;
            end
          end
          // A zero count while running is expiry.
          if (count == 26'h0000000) begin
            next_state = ST_IDLE;
            expire     = 1'b1;
          end else if (cnt_tick) begin
            next_count = count - 26'h0000001;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // A fixed-length reset pulse follows every expiry.
  always @* begin
    next_sys_rst = sys_rst;
    next_rst_cnt = rst_cnt;
    if (expire) begin
      next_sys_rst = 1'b1;
      next_rst_cnt = PULSE_LEN;
    end else if (rst_cnt > 8'h01) begin
      next_rst_cnt = rst_cnt - 8'h01;
    end else begin
      next_sys_rst = 1'b0;
      next_rst_cnt = 8'h00;
    end
  end

  // All state registers; the countdown stays idle after reset.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      initialized <= 1'b0;
      cfg_minutes <= 1'b0;
      cfg_count   <= 26'h0000000;
      state       <= ST_IDLE;
      count       <= 26'h0000000;
      presc       <= 32'h00000000;
      min_div     <= 6'h00;
      rst_cnt     <= 8'h00;
      sys_rst     <= 1'b0;
    end else begin
      initialized <= next_initialized;
      cfg_minutes <= next_cfg_minutes;
      cfg_count   <= next_cfg_count;
      state       <= next_state;
      count       <= next_count;
      presc       <= next_presc;
      min_div     <= next_min_div;
      rst_cnt     <= next_rst_cnt;
      sys_rst     <= next_sys_rst;
    end
  end

  assign initialized_out  = initialized;
  assign running_out      = running;
  assign minute_mode_out  = cfg_minutes;
  assign count_out        = count;
  assign system_reset_out = sys_rst;

endmodule // swdt_system_watchdog

// File: shared/swdt_defs.vh
/*
  Constants for the system watchdog countdown timer.
  Assumes a 100 MHz clock on mclk_in; the tick period is set by a prescaler.
*/
`ifndef SWDT_DEFS_VH
`define SWDT_DEFS_VH

`define SWDT_CLK_PERIOD_NS   10
`define SWDT_SEC_NS          1000000000
`define SWDT_SEC_CYCLES      (`SWDT_SEC_NS / `SWDT_CLK_PERIOD_NS)
`define SWDT_SECS_PER_MIN    60
`define SWDT_FINE_MAX        32'h000000FF
`define SWDT_RST_PULSE_CYC   16

`endif

// File: bench/swdt_checker.sv
/* Watchdog port assertions. Assumes the bind below. */
`timescale 1ns/10ps
module swdt_checker (input wire mclk_in, input wire rst_in, input wire timer_init_cmd_in,
  input wire timeout_config_cmd_in, input wire [31:0] timeout_seconds_in,
  input wire countdown_start_cmd_in, input wire countdown_kick_cmd_in,
  input wire countdown_stop_cmd_in, input wire initialized_out, input wire running_out,
  input wire minute_mode_out, input wire [25:0] count_out, input wire system_reset_out);
  reg [31:0] cfg;
  wire [31:0] want = (cfg > 32'hFF) ? cfg / 60 + 1 : cfg;
  wire go = initialized_out && !countdown_stop_cmd_in;
  always @(posedge mclk_in or posedge rst_in)
    if (rst_in) cfg <= 32'h0;
    else if (timeout_config_cmd_in && initialized_out) cfg <= timeout_seconds_in;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_start_loads:
    assert property (go && countdown_start_cmd_in |=> running_out &&
      count_out == $past(want[25:0]))
      else $error("bad start");
  a_minute_mode:
    assert property (go && countdown_start_cmd_in |=> minute_mode_out == (cfg > 32'hFF))
      else $error("bad units");
  a_kick_reload:
    assert property (go && countdown_kick_cmd_in |=> running_out &&
      count_out == $past(want[25:0]))
      else $error("bad kick");
  a_stop_halts:
    assert property (countdown_stop_cmd_in |=> !running_out) else $error("bad stop");
  a_expiry_cause:
    assert property ($rose(system_reset_out) |-> $past(running_out) && !running_out &&
      $past(count_out) == 26'h0) else $error("bad expiry");
  a_pulse_len:
    assert property ($rose(system_reset_out) |-> ##15 system_reset_out ##1 !system_reset_out)
      else $error("bad pulse");
  a_idle_holds:
    assert property (!running_out && !countdown_start_cmd_in && !countdown_kick_cmd_in
      |=> !running_out && !$rose(system_reset_out)) else $error("bad idle");
endmodule // swdt_checker
bind swdt_system_watchdog swdt_checker chk (.*);

// File: bench/swdt_host.sv
/* Host model: one init pulse after reset. Assumes mclk_in. */
`timescale 1ns/10ps
module swdt_host (input wire mclk_in, input wire rst_in, output reg init_out);
  reg done;
  always @(posedge mclk_in or posedge rst_in)
    if (rst_in) {init_out, done} <= 2'h0;
    else {init_out, done} <= {~done, 1'b1};
endmodule // swdt_host

// File: bench/testbench.sv
/* Watchdog bench. Assumes the watchdog built with a short second. */
`timescale 1ns/10ps
module testbench;
  reg clk = 0, rst = 1;
  reg [3:0] c = 0;
  reg [31:0] t = 0;
  wire ini, iok, run, mm, sr;
  wire [25:0] cnt;
  integer failures = 0, num_checks = 0, i;
  initial forever #5 clk = ~clk;
  swdt_host host (.mclk_in(clk), .rst_in(rst), .init_out(ini));
  swdt_system_watchdog #(.SEC_CYCLES(2)) dut (.mclk_in(clk), .rst_in(rst),
    .timer_init_cmd_in(ini), .timeout_config_cmd_in(c[0]), .timeout_seconds_in(t),
    .countdown_start_cmd_in(c[1]), .countdown_kick_cmd_in(c[2]),
    .countdown_stop_cmd_in(c[3]), .initialized_out(iok), .running_out(run),
    .minute_mode_out(mm), .count_out(cnt), .system_reset_out(sr));
  task chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin failures++; $display("BAD %0t mismatch", $time); end
  endtask
  task go(input [3:0] m, input [31:0] v);
    @(posedge clk) begin c <= m; t <= v; end
    @(posedge clk) c <= 4'h0;
    #1;
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task s_fine;
    go(4'h1, 32'h3); go(4'h2, 32'h0);
    chk(run === 1'b1 && cnt === 26'h3 && mm === 1'b0);
    for (i = 0; sr !== 1'b1 && i < 40; i++) @(posedge clk) #1;
    chk(sr === 1'b1 && run === 1'b0);
    chk(i == 7);
    if (i == 40) report_and_stop;
  endtask
  task s_coarse;
    go(4'h1, 32'h190); go(4'h2, 32'h0);
    chk(cnt === 26'h7 && mm === 1'b1);
    repeat (119) @(posedge clk); #1;
    chk(cnt === 26'h7);
    @(posedge clk) #1;
    chk(cnt === 26'h6);
    go(4'h1, 32'h2); go(4'h4, 32'h0);
    chk(run === 1'b1 && cnt === 26'h2 && mm === 1'b0);
    go(4'h8, 32'h0); repeat (40) @(posedge clk);
    chk(run === 1'b0 && sr === 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge clk); rst <= 0;
    repeat (3) @(posedge clk); #1;
    chk(iok === 1'b1 && run === 1'b0);
    s_fine; s_coarse; report_and_stop;
  end
endmodule // testbench
